// ==== hdl/pmt_pkg.sv ====
// Constants for the period match timer and its register map
//
// Operation
// - Timer ticks only from instruction clock, system clock divided by four.
// - Prescaler divides instruction clock by 1, 4 or 16 before counting.
// - Count register is eight bits wide.
// - Period register is eight bits and holds the match value.
// - Count rises from zero; on match the next increment loads zero.
// - Each match advances a postscaler programmable from 1:1 to 1:16.
// - Every postscaler output pulse sets the match interrupt flag.
// - Software may read and write count and period registers anytime.
// - Reset loads count with zero and period with all ones.
// - Timer counts only while the run bit is one.
// - Prescale and postscale ratios come from control register select fields.
// - Count write, control write and reset clear prescaler and postscaler.
// - Control register write leaves the count value unchanged.
package pmt_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int PMT_ADDR_W = 8;
    localparam logic [PMT_ADDR_W-1:0] PMT_OFS_CTRL = 8'h00;
    localparam logic [PMT_ADDR_W-1:0] PMT_OFS_COUNT = 8'h04;
    localparam logic [PMT_ADDR_W-1:0] PMT_OFS_PERIOD = 8'h08;
    localparam logic [PMT_ADDR_W-1:0] PMT_OFS_STATUS = 8'h0C;
    localparam logic [PMT_ADDR_W-1:0] PMT_OFS_MASK = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PMT_CTRL_PRE_LSB = 0;
    localparam int PMT_CTRL_RUN_BIT = 2;
    localparam int PMT_CTRL_POST_LSB = 3;
    localparam int PMT_STAT_FLAG_BIT = 0;
    localparam int PMT_MASK_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;

    // ----------------------------------------------------------------
    // Clock division and prescale codes
    // ----------------------------------------------------------------
    localparam int PMT_INSTR_DIV = 4;
    localparam logic [1:0] PMT_QDIV_LAST = 2'(PMT_INSTR_DIV - 1);
    typedef enum logic [1:0] {
        PMT_PRE_1 = 2'h0,
        PMT_PRE_4 = 2'h1,
        PMT_PRE_16 = 2'h2,
        PMT_PRE_16B = 2'h3
    } pmt_pre_t;
    localparam logic [3:0] PMT_PRE_TERM_1 = 4'h0;
    localparam logic [3:0] PMT_PRE_TERM_4 = 4'h3;
    localparam logic [3:0] PMT_PRE_TERM_16 = 4'hF;

endpackage : pmt_pkg

// ==== hdl/pmt_timer.sv ====
// Period match timer with APB register access and masked interrupt
`timescale 1ns/10ps

module pmt_timer
    import pmt_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int POST_W = 4
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PMT_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic match_flag_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic [1:0] pre_sel;
        logic [POST_W-1:0] post_sel;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] period;
        logic flag;
        logic mask;
        logic [1:0] qdiv;
        logic [3:0] pre_cnt;
        logic [POST_W-1:0] post_cnt;
        logic [31:0] rdata;
    } pmt_state_t;

    pmt_state_t st_r;
    pmt_state_t st_nxt;

    logic setup;
    logic access;
    logic wr_acc;
    logic mapped;
    logic wr_ctrl;
    logic wr_count;
    logic wr_period;
    logic wr_status;
    logic wr_mask;
    logic instr_tick;
    logic pre_done;
    logic inc_en;
    logic match;
    logic post_pulse;
    logic flag_clr;
    logic [3:0] pre_term;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign wr_acc = access && pwrite_i;

    always_comb
    begin
        unique case (paddr_i)
            PMT_OFS_CTRL, PMT_OFS_COUNT, PMT_OFS_PERIOD, PMT_OFS_STATUS, PMT_OFS_MASK:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    assign wr_ctrl = wr_acc && (paddr_i == PMT_OFS_CTRL);
    assign wr_count = wr_acc && (paddr_i == PMT_OFS_COUNT);
    assign wr_period = wr_acc && (paddr_i == PMT_OFS_PERIOD);
    assign wr_status = wr_acc && (paddr_i == PMT_OFS_STATUS);
    assign wr_mask = wr_acc && (paddr_i == PMT_OFS_MASK);

    // Zero wait states keep the answer one access cycle long
    assign pready_o = 1'b1;
    // Unmapped access errors out, reads zero, writes nothing
    assign pslverr_o = access && !mapped;

    // ----------------------------------------------------------------
    // Timing chain
    // ----------------------------------------------------------------
    // instruction clock tick
    assign instr_tick = (st_r.qdiv == PMT_QDIV_LAST);

    always_comb
    begin
        unique case (pmt_pre_t'(st_r.pre_sel))
            PMT_PRE_1: pre_term = PMT_PRE_TERM_1;
            PMT_PRE_4: pre_term = PMT_PRE_TERM_4;
            PMT_PRE_16, PMT_PRE_16B: pre_term = PMT_PRE_TERM_16;
        endcase
    end

    assign pre_done = (st_r.pre_cnt == pre_term);
    assign inc_en = st_r.run && instr_tick && pre_done;
    assign match = (st_r.count == st_r.period);
    assign post_pulse = inc_en && match && (st_r.post_cnt == st_r.post_sel);
    assign flag_clr = wr_status && !pwdata_i[PMT_STAT_FLAG_BIT];

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_val = '0;
        unique case (paddr_i)
            PMT_OFS_CTRL:
            begin
                rd_val[PMT_CTRL_PRE_LSB +: 2] = st_r.pre_sel;
                rd_val[PMT_CTRL_RUN_BIT] = st_r.run;
                rd_val[PMT_CTRL_POST_LSB +: POST_W] = st_r.post_sel;
            end
            PMT_OFS_COUNT: rd_val[CNT_W-1:0] = st_r.count;
            PMT_OFS_PERIOD: rd_val[CNT_W-1:0] = st_r.period;
            PMT_OFS_STATUS: rd_val[PMT_STAT_FLAG_BIT] = st_r.flag;
            PMT_OFS_MASK: rd_val[PMT_MASK_BIT] = st_r.mask;
            default: rd_val = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // Free-running divider, so writes never shift its phase
        st_nxt.qdiv = 2'(st_r.qdiv + 2'h1);
        // Captured in setup so prdata comes from a flip-flop
        if (setup && !pwrite_i)
        begin
            st_nxt.rdata = rd_val;
        end
        if (instr_tick && st_r.run)
        begin
            st_nxt.pre_cnt = pre_done ? 4'h0 : 4'(st_r.pre_cnt + 4'h1);
        end
        if (inc_en)
        begin
            if (match)
            begin
                st_nxt.count = '0;
                st_nxt.post_cnt = (st_r.post_cnt == st_r.post_sel) ? '0
                    : POST_W'(st_r.post_cnt + 1'b1);
            end
            else
            begin
                st_nxt.count = CNT_W'(st_r.count + 1'b1);
            end
        end
        // postscaler pulse sets flag, and wins over a clear
        st_nxt.flag = (st_r.flag && !flag_clr) || post_pulse;
        // Write wins over a same-cycle increment
        // software access to count and period
        if (wr_count)
        begin
            st_nxt.count = pwdata_i[CNT_W-1:0];
        end
        if (wr_period)
        begin
            st_nxt.period = pwdata_i[CNT_W-1:0];
        end
        if (wr_ctrl)
        begin
            // count is left as it stands
            st_nxt.run = pwdata_i[PMT_CTRL_RUN_BIT];
            st_nxt.pre_sel = pwdata_i[PMT_CTRL_PRE_LSB +: 2];
            st_nxt.post_sel = pwdata_i[PMT_CTRL_POST_LSB +: POST_W];
        end
        if (wr_mask)
        begin
            st_nxt.mask = pwdata_i[PMT_MASK_BIT];
        end
        if (wr_count || wr_ctrl)
        begin
            st_nxt.pre_cnt = 4'h0;
            st_nxt.post_cnt = '0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.count <= CNT_W'(PMT_COUNT_RST);
            st_r.period <= CNT_W'(PMT_PERIOD_RST);
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata_o = st_r.rdata;
    assign match_flag_o = st_r.flag;
    assign irq_o = st_r.flag && st_r.mask;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence quiet_s;
        !wr_count && !wr_ctrl && !wr_period;
    endsequence

    sequence tick_gap_s;
        !instr_tick [*3] ##1 instr_tick;
    endsequence

    sequence slow_gap_s;
        !inc_en [*8] ##1 !inc_en [*8];
    endsequence

    instr_tick_a: assert property (instr_tick |=> tick_gap_s)
        else $error("instruction tick not every fourth clock");

    count_step_a: assert property ((inc_en && !match) and quiet_s |=>
        st_r.count == CNT_W'($past(st_r.count) + 1'b1))
        else $error("count did not step by one");

    count_hold_a: assert property (!st_r.run && !wr_count |=> $stable(st_r.count))
        else $error("count moved while stopped");

    match_wrap_a: assert property (inc_en && match && !wr_count |=> st_r.count == '0)
        else $error("count did not wrap on match");

    post_flag_a: assert property (post_pulse |=> st_r.flag && irq_o == st_r.mask)
        else $error("postscaler pulse lost");

    flag_sticky_a: assert property (st_r.flag && !flag_clr |=> st_r.flag)
        else $error("flag dropped without clear");

    reset_vals_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        !rst_n_i |=> st_r.count == '0 && st_r.period == '1)
        else $error("reset values wrong");

    ctrl_write_a: assert property (wr_ctrl |=>
        st_r.pre_cnt == 4'h0 && st_r.post_cnt == '0)
        else $error("control write left scalers running");

    ctrl_keep_a: assert property (wr_ctrl && !inc_en |=> $stable(st_r.count))
        else $error("control write moved count");

    period_wr_a: assert property (wr_period |=> st_r.period == $past(pwdata_i[CNT_W-1:0]))
        else $error("period write lost");

    pre_four_a: assert property ((st_r.run && st_r.pre_sel == PMT_PRE_4 && inc_en) and quiet_s
        |=> !inc_en [*8])
        else $error("prescale 1:4 too fast");

    count_wr_a: assert property (wr_count |=> st_r.count == $past(pwdata_i[CNT_W-1:0]))
        else $error("count write lost");

    count_clear_a: assert property (wr_count |=>
        st_r.pre_cnt == 4'h0 && st_r.post_cnt == '0)
        else $error("count write left scalers running");

    reset_scal_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        !rst_n_i |=> st_r.pre_cnt == 4'h0 && st_r.post_cnt == '0 && !st_r.flag)
        else $error("reset left scaler state");

    flag_clear_a: assert property (flag_clr && !post_pulse |=> !st_r.flag)
        else $error("flag clear lost");

    // flag rises only on postscaler pulse
    flag_idle_a: assert property (!st_r.flag && !post_pulse |=> !st_r.flag)
        else $error("flag set without postscaler pulse");

    pre_one_a: assert property (st_r.run && st_r.pre_sel == PMT_PRE_1 && instr_tick
        |-> inc_en)
        else $error("prescale 1:1 missed a tick");

    pre_range_a: assert property (st_r.pre_cnt <= pre_term)
        else $error("prescaler beyond terminal count");

    pre_sixteen_a: assert property ((st_r.run && st_r.pre_sel[1] && inc_en) and quiet_s
        |=> slow_gap_s)
        else $error("prescale 1:16 too fast");

    post_range_a: assert property (st_r.post_cnt <= st_r.post_sel)
        else $error("postscaler beyond its ratio");

    post_one_a: assert property (inc_en && match && st_r.post_sel == '0 |-> post_pulse)
        else $error("postscale 1:1 missed a match");

    post_step_a: assert property (inc_en && match && st_r.post_cnt != st_r.post_sel
        && !wr_ctrl && !wr_count |=>
        st_r.post_cnt == POST_W'($past(st_r.post_cnt) + 1'b1))
        else $error("postscaler did not advance");

    period_hold_a: assert property (!wr_period |=> $stable(st_r.period))
        else $error("period changed without write");

endmodule : pmt_timer

// ==== tb/pmt_timer_tb.sv ====
// Self-checking bench for the period match timer
`timescale 1ns/10ps

module pmt_timer_tb
    import pmt_pkg::*;
;

`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e); \
        end \
    end

    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, match_flag_o, irq_o;
    logic [31:0] rd, v;
    logic err;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 1833;
    int per, post, tmo;

    pmt_timer i_pmt_timer (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .match_flag_o, .irq_o);

    always #25 core_clk_i = ~core_clk_i;

    // ----------------------------------------------------------------
    // Tasks and expectation helpers
    // ----------------------------------------------------------------
    task complete_run;
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Cap well above the longest match wait
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            errors++;
            complete_run();
        end
    end

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do
            @(posedge core_clk_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rdc

    // Lets the edge's updates land before sampling
    task idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : idle

    function int pre_ratio(input logic [1:0] c);
        return (c == 2'h0) ? 1 : ((c == 2'h1) ? 4 : 16);
    endfunction : pre_ratio

    // Edge of flag set after a control write; phase of quarter divider adds -1..-4
    function int flag_time(input int r, input int p, input int n);
        return 4 * r * (p + 1) * (n + 1) + 1;
    endfunction : flag_time

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rdc(PMT_OFS_COUNT, 32'h0);
        rdc(PMT_OFS_PERIOD, 32'hFF);
        rdc(PMT_OFS_CTRL, 32'h0);
        rdc(PMT_OFS_STATUS, 32'h0);
        `CHK(err, 1'b0)
        `CHK(pready_o, 1'b1)
        wr(8'h14, $random(seed));
        `CHK(err, 1'b1)
        rdc(8'h14, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(PMT_OFS_PERIOD, v);
            rdc(PMT_OFS_PERIOD, {24'h0, v[7:0]});
            wr(PMT_OFS_COUNT, v >> 8);
            rdc(PMT_OFS_COUNT, {24'h0, v[15:8]});
        end
        for (int c = 0; c < 4; c++)
        begin
            per = (c == 0) ? 0 : {$random(seed)} % 8;
            post = (c == 3) ? 15 : ((c == 0) ? 0 : {$random(seed)} % 4);
            wr(PMT_OFS_CTRL, 32'h0);
            wr(PMT_OFS_STATUS, 32'h0);
            wr(PMT_OFS_COUNT, 32'h0);
            wr(PMT_OFS_PERIOD, per);
            tmo = flag_time(pre_ratio(c[1:0]), per, post);
            wr(PMT_OFS_CTRL, (post << 3) | 4 | c);
            idle(tmo - 5);
            `CHK(match_flag_o, 1'b0)
            idle(4);
            `CHK(match_flag_o, 1'b1)
        end
        wr(PMT_OFS_CTRL, 32'h3);
        apb(1'b0, PMT_OFS_COUNT, 32'h0);
        v = rd;
        idle(100);
        rdc(PMT_OFS_COUNT, v);
        wr(PMT_OFS_COUNT, 32'hA5);
        wr(PMT_OFS_CTRL, 32'h7);
        wr(PMT_OFS_CTRL, 32'h3);
        rdc(PMT_OFS_COUNT, 32'hA5);
        wr(PMT_OFS_PERIOD, 32'hFF);
        wr(PMT_OFS_CTRL, 32'h6);
        // Leave the prescaler part way so a missed clear shows
        idle(37);
        wr(PMT_OFS_COUNT, 32'h0);
        idle(56);
        rdc(PMT_OFS_COUNT, 32'h0);
        idle(10);
        rdc(PMT_OFS_COUNT, 32'h1);
        wr(PMT_OFS_CTRL, 32'h0);
        `CHK(irq_o, 1'b0)
        wr(PMT_OFS_MASK, 32'h1);
        idle(1);
        `CHK(irq_o, 1'b1)
        wr(PMT_OFS_STATUS, 32'h1);
        rdc(PMT_OFS_STATUS, 32'h1);
        wr(PMT_OFS_STATUS, 32'h0);
        idle(1);
        `CHK(match_flag_o, 1'b0)
        `CHK(irq_o, 1'b0)
        complete_run();
    end

endmodule : pmt_timer_tb
